/* File: hdl/sleep_clock_gating_control.sv */
// Purpose: run, sleep and deep-sleep clock gating with apb register access
// Assumes: unit access strobes and mode requests synchronous to pclk
// Notes:   one wait state on every apb transfer
`timescale 1ns/1ps
`include "clock_gate_defines.svh"
module sleep_clock_gating_control
    import clock_gate_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // power mode requests from the core
    input  wire logic        sleep_req,
    input  wire logic        deep_sleep_req,
    // unit bus access strobes: watchdog, adc, pwm
    input  wire logic        watchdog_access,
    input  wire logic        adc_access,
    input  wire logic        pwm_access,
    // unit clock enables and adc sample rate select
    output logic             watchdog_clock_enable,
    output logic             adc_clock_enable,
    output logic             pwm_clock_enable,
    output logic      [1:0]  adc_sample_rate_select,
    // fault and interrupt
    output logic             bus_fault,
    output logic             irq
);

    // ----------------------------------------------------------------
    // register map, byte offsets on paddr
    // ----------------------------------------------------------------
    // 0x060  run mode clock config
    //        bit 0     auto gating select: sleep and deep words apply
    // 0x100  run gating word
    // 0x110  sleep gating word
    // 0x120  deep-sleep gating word
    //        bit 20    pwm clock enable
    //        bit 16    adc clock enable
    //        bits 9:8  adc sample rate select
    //        bit 6     reads one, ignores writes
    //        bit 3     watchdog clock enable
    //        others    read zero, ignore writes
    // 0x140  fault status, sticky, write one to clear
    // 0x144  fault interrupt mask
    //        bit 2     pwm access while gated
    //        bit 1     adc access while gated
    //        bit 0     watchdog access while gated
    // any other offset answers with pslverr and reads zero
    // rate codes 2 and 3 are stored as written; keeping to the
    // supported rate is left to software

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    word_t       run_clock_gate_0_ff;
    word_t       sleep_clock_gate_0_ff;
    word_t       deep_sleep_clock_gate_0_ff;
    word_t       run_mode_clock_config_ff;
    logic  [2:0] irq_status_ff;
    logic  [2:0] irq_mask_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    word_t       prdata_ff;
    power_mode_t mode_ff;
    logic  [1:0] rate_ff;
    logic        bus_fault_ff;
    logic        irq_ff;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    wire access_phase = psel & penable;
    wire xfer_done    = access_phase & pready_ff;
    wire wr_xfer      = xfer_done & pwrite;

    wire sel_config = (paddr == `OFS_RUN_CLOCK_CONFIG);
    wire sel_run    = (paddr == `OFS_RUN_GATE);
    wire sel_sleep  = (paddr == `OFS_SLEEP_GATE);
    wire sel_deep   = (paddr == `OFS_DEEP_GATE);
    wire sel_status = (paddr == `OFS_IRQ_STATUS);
    wire sel_mask   = (paddr == `OFS_IRQ_MASK);
    wire mapped     = sel_config | sel_run | sel_sleep | sel_deep
                    | sel_status | sel_mask;

    // one strobe per register, high only in the completing access cycle
    wire wr_config     = wr_xfer & sel_config;
    wire wr_run_gate   = wr_xfer & sel_run;
    wire wr_sleep_gate = wr_xfer & sel_sleep;
    wire wr_deep_gate  = wr_xfer & sel_deep;
    wire wr_status     = wr_xfer & sel_status;
    wire wr_irq_mask   = wr_xfer & sel_mask;

    // reserved bits stay at their reset value, only documented fields move
    wire [31:0] gate_keep = ~`WR_MASK_GATE;
    wire [31:0] cfg_keep  = ~`WR_MASK_CONFIG;

    wire [31:0] nxt_run    = (run_clock_gate_0_ff & gate_keep)
                           | (pwdata & `WR_MASK_GATE);
    wire [31:0] nxt_sleep  = (sleep_clock_gate_0_ff & gate_keep)
                           | (pwdata & `WR_MASK_GATE);
    wire [31:0] nxt_deep   = (deep_sleep_clock_gate_0_ff & gate_keep)
                           | (pwdata & `WR_MASK_GATE);
    wire [31:0] nxt_config = (run_mode_clock_config_ff & cfg_keep)
                           | (pwdata & `WR_MASK_CONFIG);

    wire [31:0] rd_status = {29'h0, irq_status_ff};
    wire [31:0] rd_mask   = {29'h0, irq_mask_ff};

    wire [31:0] nxt_prdata =
          sel_config ? run_mode_clock_config_ff
        : sel_run    ? run_clock_gate_0_ff
        : sel_sleep  ? sleep_clock_gate_0_ff
        : sel_deep   ? deep_sleep_clock_gate_0_ff
        : sel_status ? rd_status
        : sel_mask   ? rd_mask
        : 32'h0000_0000;

    // ----------------------------------------------------------------
    // apb handshake: pready rises in the first access cycle's edge
    // ----------------------------------------------------------------
    // one fixed wait state lets read data leave a register, not a mux
    wire nxt_pready  = access_phase & ~pready_ff;
    wire nxt_pslverr = access_phase & ~pready_ff & ~mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else if (ce) begin
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff  <= (nxt_pready & ~pwrite) ? nxt_prdata : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // gating registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_clock_gate_0_ff <= `RST_GATE;
        end else if (ce && wr_run_gate) begin
            run_clock_gate_0_ff <= nxt_run;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_clock_gate_0_ff <= `RST_GATE;
        end else if (ce && wr_sleep_gate) begin
            sleep_clock_gate_0_ff <= nxt_sleep;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            deep_sleep_clock_gate_0_ff <= `RST_GATE;
        end else if (ce && wr_deep_gate) begin
            deep_sleep_clock_gate_0_ff <= nxt_deep;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_mode_clock_config_ff <= `RST_CONFIG;
        end else if (ce && wr_config) begin
            run_mode_clock_config_ff <= nxt_config;
        end
    end

    // ----------------------------------------------------------------
    // power mode tracking
    // ----------------------------------------------------------------
    // deep sleep outranks plain sleep when both are requested
    wire auto_clock_gating_select = run_mode_clock_config_ff[`BIT_AUTO_GATING];

    power_mode_t nxt_mode;
    always_comb begin
        nxt_mode = mode_run;
        case (mode_ff)
            mode_run: begin
                if (deep_sleep_req) begin
                    nxt_mode = mode_deep;
                end else if (sleep_req) begin
                    nxt_mode = mode_sleep;
                end
            end
            mode_sleep: begin
                if (deep_sleep_req) begin
                    nxt_mode = mode_deep;
                end else if (sleep_req) begin
                    nxt_mode = mode_sleep;
                end
            end
            mode_deep: begin
                if (deep_sleep_req) begin
                    nxt_mode = mode_deep;
                end else if (sleep_req) begin
                    nxt_mode = mode_sleep;
                end
            end
            default: begin
                nxt_mode = mode_run;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff <= mode_run;
        end else if (ce) begin
            mode_ff <= nxt_mode;
        end
    end

    // ----------------------------------------------------------------
    // active gating word
    // ----------------------------------------------------------------
    // without auto gating the run settings hold in every mode
    wire use_sleep = auto_clock_gating_select & (mode_ff == mode_sleep);
    wire use_deep  = auto_clock_gating_select & (mode_ff == mode_deep);

    wire [31:0] active_gate = use_deep  ? deep_sleep_clock_gate_0_ff
                            : use_sleep ? sleep_clock_gate_0_ff
                            : run_clock_gate_0_ff;

    wire [`NUM_UNITS-1:0] unit_enable = {active_gate[`BIT_PWM],
                                         active_gate[`BIT_ADC],
                                         active_gate[`BIT_WATCHDOG]};
    wire [`NUM_UNITS-1:0] unit_access = {pwm_access, adc_access, watchdog_access};

    // rate follows the active word; 2 and 3 are passed unchecked
    wire [1:0] nxt_rate = active_gate[`RATE_HI:`RATE_LO];

    // ----------------------------------------------------------------
    // per unit gate cells
    // ----------------------------------------------------------------
    wire [`NUM_UNITS-1:0] unit_clk_en;
    wire [`NUM_UNITS-1:0] unit_fault;

    // vector bit order: 0 watchdog, 1 adc, 2 pwm
    unit_gate_cell u_unit_gate_cell_wd (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .gate_en   (unit_enable[0]),
        .access    (unit_access[0]),
        .clk_en_ff (unit_clk_en[0]),
        .fault_ff  (unit_fault[0])
    );

    unit_gate_cell u_unit_gate_cell_adc (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .gate_en   (unit_enable[1]),
        .access    (unit_access[1]),
        .clk_en_ff (unit_clk_en[1]),
        .fault_ff  (unit_fault[1])
    );

    unit_gate_cell u_unit_gate_cell_pwm (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .gate_en   (unit_enable[2]),
        .access    (unit_access[2]),
        .clk_en_ff (unit_clk_en[2]),
        .fault_ff  (unit_fault[2])
    );

    // ----------------------------------------------------------------
    // fault pulse, rate output
    // ----------------------------------------------------------------
    // second register stage: bus_fault stands two edges after the strobe
    wire nxt_bus_fault = |unit_fault;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_fault_ff <= 1'b0;
            rate_ff      <= `RATE_125K;
        end else if (ce) begin
            bus_fault_ff <= nxt_bus_fault;
            rate_ff      <= nxt_rate;
        end
    end

    // ----------------------------------------------------------------
    // interrupt status and mask
    // ----------------------------------------------------------------
    // a fault landing in the clearing cycle survives: set beats clear
    wire [2:0] status_clr = wr_status ? pwdata[2:0] : 3'h0;
    wire [2:0] nxt_status = (irq_status_ff & ~status_clr) | unit_fault;
    wire [2:0] nxt_mask   = wr_irq_mask ? pwdata[2:0] : irq_mask_ff;
    wire       nxt_irq    = |(nxt_status & nxt_mask);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_ff <= 3'h0;
        end else if (ce) begin
            irq_status_ff <= nxt_status;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_ff <= 3'h0;
        end else if (ce) begin
            irq_mask_ff <= nxt_mask;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
        end else if (ce) begin
            irq_ff <= nxt_irq;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign prdata                 = prdata_ff;
    assign pready                 = pready_ff;
    assign pslverr                = pslverr_ff;
    assign watchdog_clock_enable  = unit_clk_en[0];
    assign adc_clock_enable       = unit_clk_en[1];
    assign pwm_clock_enable       = unit_clk_en[2];
    assign adc_sample_rate_select = rate_ff;
    assign bus_fault              = bus_fault_ff;
    assign irq                    = irq_ff;

endmodule : sleep_clock_gating_control

/* File: hdl/clock_gate_defines.svh */
// Purpose: offsets, field positions, reset values of the clock gating block
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   included by the main module only; the package does not include it
`ifndef CLOCK_GATE_DEFINES_SVH
`define CLOCK_GATE_DEFINES_SVH

// --------------------------------------------------------------------
// register byte offsets
// --------------------------------------------------------------------
`define OFS_RUN_CLOCK_CONFIG   12'h060
`define OFS_RUN_GATE           12'h100
`define OFS_SLEEP_GATE         12'h110
`define OFS_DEEP_GATE          12'h120
`define OFS_IRQ_STATUS         12'h140
`define OFS_IRQ_MASK           12'h144

// --------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------
`define BIT_WATCHDOG           3
`define BIT_ADC                16
`define BIT_PWM                20
`define RATE_LO                8
`define RATE_HI                9
`define BIT_AUTO_GATING        0

// --------------------------------------------------------------------
// reset values and masks
// --------------------------------------------------------------------
`define RST_GATE               32'h0000_0040
`define WR_MASK_GATE           32'h0011_0308
`define RST_CONFIG             32'h0000_0000
`define WR_MASK_CONFIG         32'h0000_0001
`define NUM_UNITS              3
`define RATE_250K              2'h1
`define RATE_125K              2'h0

`endif

/* File: hdl/clock_gate_pkg.sv */
// Purpose: shared types of the clock gating block
// Assumes: nothing beyond the defines header
// Notes:   power modes are one-hot
package clock_gate_pkg;

    typedef enum logic [2:0] {
        mode_run   = 3'b001,
        mode_sleep = 3'b010,
        mode_deep  = 3'b100
    } power_mode_t;

    typedef logic [31:0] word_t;

endpackage : clock_gate_pkg

/* File: hdl/unit_gate_cell.sv */
// Purpose: clock enable and fault flag for one gated unit
// Assumes: access strobe is one cycle per unit bus transfer
// Notes:   instantiated once per unit
`timescale 1ns/1ps
module unit_gate_cell (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ce,
    // control
    input  wire logic gate_en,
    input  wire logic access,
    // results
    output logic      clk_en_ff,
    output logic      fault_ff
);

    wire nxt_fault = access & ~gate_en;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_en_ff <= 1'b0;
            fault_ff  <= 1'b0;
        end else if (ce) begin
            clk_en_ff <= gate_en;
            fault_ff  <= nxt_fault;
        end
    end

endmodule : unit_gate_cell

/* File: testbench/clock_gate_chk.sv */
// Purpose: bus and gating checks on the clock gating block
// Assumes: one pclk domain, presetn asynchronous active low
// Notes:   bound at the foot of this file
`timescale 1ns/1ps
module clock_gate_chk (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // units
    input wire logic        watchdog_access,
    input wire logic        adc_access,
    input wire logic        pwm_access,
    input wire logic        watchdog_clock_enable,
    input wire logic        adc_clock_enable,
    input wire logic        pwm_clock_enable,
    input wire logic [1:0]  adc_sample_rate_select,
    input wire logic        bus_fault
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    ready_ack_a: assert property (ce && psel && penable && !pready |=> pready)
        else $error("no pready after access phase");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    read_zero_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
        else $error("prdata not zero outside read");
    reset_off_a: assert property (!$past(presetn) |->
        {watchdog_clock_enable, adc_clock_enable, pwm_clock_enable, adc_sample_rate_select} == 5'h0)
        else $error("unit clocked after reset");
    // enable output lags by one edge, bus_fault by two, hence ##1 then |=>
    wdt_fault_a: assert property ((ce && watchdog_access) ##1
        (ce && !watchdog_clock_enable) |=> bus_fault)
        else $error("no fault on gated watchdog");
    adc_fault_a: assert property ((ce && adc_access) ##1
        (ce && !adc_clock_enable) |=> bus_fault)
        else $error("no fault on gated adc");
    pwm_fault_a: assert property ((ce && pwm_access) ##1
        (ce && !pwm_clock_enable) |=> bus_fault)
        else $error("no fault on gated pwm");
    no_fault_a: assert property ((ce && !(watchdog_access || adc_access || pwm_access))
        ##1 ce |=> !bus_fault)
        else $error("fault without access");
endmodule : clock_gate_chk

bind sleep_clock_gating_control clock_gate_chk u_clock_gate_chk (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
    .watchdog_access, .adc_access, .pwm_access, .watchdog_clock_enable,
    .adc_clock_enable, .pwm_clock_enable, .adc_sample_rate_select, .bus_fault);

/* File: testbench/tb_top.sv */
// Purpose: directed register, mode and fault tests of the clock gating block
// Assumes: enables settle two edges after a write or a mode request
// Notes:   ce dropped once to show that the mode state freezes
`timescale 1ns/1ps
module tb_top
    import clock_gate_pkg::*;
;
    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
    logic        sleep_req, deep_sleep_req, bus_fault, irq, wd_en, adc_en, pwm_en;
    logic [2:0]  acc;
    logic [1:0]  rate;
    logic [11:0] paddr;
    word_t       pwdata, prdata, rd;
    int          fails, comparisons;

    sleep_clock_gating_control u_sleep_clock_gating_control (
        .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .sleep_req, .deep_sleep_req,
        .watchdog_access(acc[0]), .adc_access(acc[1]), .pwm_access(acc[2]),
        .watchdog_clock_enable(wd_en), .adc_clock_enable(adc_en),
        .pwm_clock_enable(pwm_en), .adc_sample_rate_select(rate), .bus_fault, .irq);

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input word_t seen, input word_t exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    function automatic word_t state();
        return {27'h0, rate, pwm_en, adc_en, wd_en};
    endfunction : state

    // idle edge at the end keeps psel from being assigned twice in one step
    task automatic apb(input logic w, input logic [11:0] a, input word_t d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // only the watchdog ends a wait that never sees pready
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rc(input string what, input logic [11:0] a, input word_t exp);
        apb(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask : rc

    task automatic settle();
        repeat (3) @(posedge pclk);
    endtask : settle

    // bus_fault is registered twice: it stands two edges after the strobe
    task automatic hit(input int u, input logic f);
        acc <= 3'h1 << u;
        @(posedge pclk);
        acc <= 3'h0;
        repeat (2) @(posedge pclk);
        chk("fault", {31'h0, bus_fault}, {31'h0, f});
    endtask : hit

    task automatic end_sim();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, sleep_req, deep_sleep_req} = 6'h0;
        ce = 1'b1;
        acc = 3'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        fails = 0;
        comparisons = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rc("sleep reset", 12'h110, 32'h0000_0040);
        rc("run reset", 12'h100, 32'h0000_0040);
        chk("enables reset", state(), 32'h0);
        $display("test reset done");
        // rate field kept at 1, the highest rate
        apb(1'b1, 12'h110, 32'hffff_fdff);
        rc("sleep masked", 12'h110, 32'h0011_0148);
        apb(1'b1, 12'h100, 32'h0000_0108);
        settle();
        chk("run wd rate1", state(), 32'h9);
        apb(1'b1, 12'h100, 32'h0001_0000);
        settle();
        chk("run adc rate0", state(), 32'h2);
        apb(1'b0, 12'h104, 32'h0);
        chk("unmapped err", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        $display("test registers done");
        apb(1'b1, 12'h120, 32'h0010_0000);
        sleep_req <= 1'b1;
        settle();
        chk("sleep no auto", state(), 32'h2);
        apb(1'b1, 12'h060, 32'h1);
        settle();
        chk("sleep word", state(), 32'hf);
        deep_sleep_req <= 1'b1;
        settle();
        chk("deep word", state(), 32'h4);
        sleep_req <= 1'b0;
        deep_sleep_req <= 1'b0;
        settle();
        chk("run word", state(), 32'h2);
        ce <= 1'b0;
        sleep_req <= 1'b1;
        settle();
        chk("frozen", state(), 32'h2);
        ce <= 1'b1;
        settle();
        chk("thawed", state(), 32'hf);
        sleep_req <= 1'b0;
        settle();
        $display("test modes done");
        apb(1'b1, 12'h144, 32'h1);
        hit(0, 1'b1);
        hit(1, 1'b0);
        hit(2, 1'b1);
        settle();
        chk("irq set", {31'h0, irq}, 32'h1);
        rc("status", 12'h140, 32'h5);
        apb(1'b1, 12'h140, 32'h1);
        settle();
        chk("irq clear", {31'h0, irq}, 32'h0);
        apb(1'b1, 12'h144, 32'h7);
        settle();
        chk("irq unmask", {31'h0, irq}, 32'h1);
        apb(1'b1, 12'h140, 32'h4);
        settle();
        chk("irq done", {31'h0, irq}, 32'h0);
        $display("test faults done");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("enables rereset", state(), 32'h0);
        rc("sleep rereset", 12'h110, 32'h0000_0040);
        rc("status rereset", 12'h140, 32'h0);
        $display("test second reset done");
        end_sim();
    end

    // tests need well under a thousand cycles
    initial begin
        repeat (3000) @(posedge pclk);
        fails++;
        end_sim();
    end
endmodule : tb_top
